// file: awu_pkg.sv
// package of constants and types for the auto wake-from-halt unit
package awu_pkg;
    // register byte addresses (offsets not multiples of four -> index*4)
    localparam logic [7:0] AWU_CSR_IDX = 8'h2e;
    localparam logic [7:0] AWU_PR_IDX = 8'h2f;
    localparam logic [11:0] AWU_CSR_ADDR = {2'h0, AWU_CSR_IDX, 2'h0};
    localparam logic [11:0] AWU_PR_ADDR = {2'h0, AWU_PR_IDX, 2'h0};
    localparam logic [11:0] AWU_IST_ADDR = 12'h0c0;
    localparam logic [11:0] AWU_IMSK_ADDR = 12'h0c4;
    localparam logic [11:0] AWU_MODE_ADDR = 12'h0c8;
    // control/status field positions
    localparam int AWU_EN_BIT = 0;
    localparam int AWU_MEAS_BIT = 1;
    localparam int AWU_FLAG_BIT = 2;
    // reset values and the interrupt mask forced on halt entry
    localparam logic [7:0] AWU_CSR_RST = 8'h00;
    localparam logic [7:0] AWU_PR_RST = 8'hff;
    localparam logic [1:0] AWU_IMASK_HALT = 2'h2;
    // fixed divider of the wake oscillator
    localparam logic [5:0] AWU_FIXED_DIV_LAST = 6'h3f;
    // stabilisation waits in main clock cycles
    localparam int AWU_STAB_SHORT = 256;
    localparam int AWU_STAB_LONG = 4096;
    localparam logic [12:0] AWU_STAB_SHORT_CNT = 13'(AWU_STAB_SHORT);
    localparam logic [12:0] AWU_STAB_LONG_CNT = 13'(AWU_STAB_LONG);
    // interrupt status bits
    localparam int AWU_IRQ_WAKE = 0;
    localparam int AWU_IRQ_EXIT = 1;
    // AXI responses
    localparam logic [1:0] AWU_RESP_OKAY = 2'h0;
    localparam logic [1:0] AWU_RESP_SLVERR = 2'h2;

    // power mode of the device
    typedef enum logic [2:0] {
        AWU_RUN = 3'b000,
        AWU_HALT = 3'b001,
        AWU_ACTIVE_HALT = 3'b010,
        AWU_WAKE_HALT = 3'b011,
        AWU_STARTUP = 3'b100,
        AWU_WDG_RESET = 3'b101
    } awu_mode_t;
endpackage

// file: awu_top.sv
// auto wake-from-halt unit with AXI4-Lite register slave
`timescale 1ns/1ns

module awu_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic halt_exec,
    input wire logic rtc_interrupt_enable,
    input wire logic watchdog_enabled,
    input wire logic watchdog_halt_option,
    input wire logic long_startup_option,
    input wire logic halt_exit_irq,
    input wire logic wake_osc_clk,
    input wire logic wake_osc_ready,
    output logic wake_osc_enable,
    output logic main_osc_enable,
    output logic periph_clk_enable,
    output logic cpu_resume,
    output logic [1:0] interrupt_mask_force,
    output logic interrupt_mask_force_en,
    output logic watchdog_reset_req,
    output logic timer_capture_input_two,
    output logic wake_irq,
    output logic irq
);
    import awu_pkg::*;

    // ******************************************************
    // state
    // ******************************************************
    typedef struct packed {
        logic aw_full;
        logic [11:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] csr;
        logic [7:0] pr;
        logic [1:0] ist;
        logic [1:0] imsk;
        awu_mode_t mode;
        logic [5:0] fix_cnt;
        logic [7:0] pre_cnt;
        logic osc_q;
        logic osc_prev;
        logic [12:0] stab_cnt;
        logic wake_pend;
        logic wake_osc_en;
        logic main_osc_en;
        logic periph_en;
        logic resume;
        logic [1:0] imask;
        logic imask_en;
        logic wdg_rst;
        logic cap2;
        logic wirq;
        logic irq;
    } awu_state_t;

    awu_state_t st_reg;
    awu_state_t st_next;
    logic wr_fire;
    logic rd_fire;
    logic osc_rise;
    logic wake_set;
    logic exit_set;
    logic csr_read;
    logic [11:0] rd_addr;
    logic [31:0] rd_val;
    logic rd_ok;
    logic wr_ok;

    // ******************************************************
    // combinational next state
    // ******************************************************
    always_comb begin
        st_next = st_reg;
        wr_fire = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
        rd_fire = s_axi_arvalid && !st_reg.rvalid;
        rd_addr = s_axi_araddr;
        osc_rise = st_reg.osc_q && !st_reg.osc_prev;
        wake_set = 1'b0;
        exit_set = 1'b0;
        csr_read = 1'b0;
        rd_val = 32'h0000_0000;
        rd_ok = 1'b1;
        wr_ok = 1'b1;

        // wake clock sampled into main domain (single stage + edge)
        st_next.osc_q = wake_osc_clk;
        st_next.osc_prev = st_reg.osc_q;

        // write address and data taken independently
        if (s_axi_awvalid && !st_reg.aw_full) begin
            st_next.aw_full = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.w_full) begin
            st_next.w_full = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end

        // register writes
        if (wr_fire) begin
            st_next.aw_full = 1'b0;
            st_next.w_full = 1'b0;
            st_next.bvalid = 1'b1;
            if (st_reg.aw_addr == AWU_CSR_ADDR) begin
                if (st_reg.w_strb[0]) begin
                    // flag bit and bits 7:3 not writable
                    st_next.csr[AWU_EN_BIT] = st_reg.w_data[AWU_EN_BIT];
                    st_next.csr[AWU_MEAS_BIT] = st_reg.w_data[AWU_MEAS_BIT];
                end
            end else if (st_reg.aw_addr == AWU_PR_ADDR) begin
                // a zero write leaves the prescaler unchanged
                if (st_reg.w_strb[0] && st_reg.w_data[7:0] != 8'h00) begin
                    st_next.pr = st_reg.w_data[7:0];
                end
            end else if (st_reg.aw_addr == AWU_IST_ADDR) begin
                if (st_reg.w_strb[0]) begin
                    st_next.ist = st_reg.ist & ~st_reg.w_data[1:0];
                end
            end else if (st_reg.aw_addr == AWU_IMSK_ADDR) begin
                if (st_reg.w_strb[0]) begin
                    st_next.imsk = st_reg.w_data[1:0];
                end
            end else if (st_reg.aw_addr == AWU_MODE_ADDR) begin
                wr_ok = 1'b1;
            end else begin
                wr_ok = 1'b0;
            end
            st_next.bresp = wr_ok ? AWU_RESP_OKAY : AWU_RESP_SLVERR;
        end

        // register reads
        if (rd_addr == AWU_CSR_ADDR) begin
            rd_val = {24'h00_0000, 5'h00, st_reg.csr[2:0]};
            csr_read = rd_fire;
        end else if (rd_addr == AWU_PR_ADDR) begin
            rd_val = {24'h00_0000, st_reg.pr};
        end else if (rd_addr == AWU_IST_ADDR) begin
            rd_val = {30'h0000_0000, st_reg.ist};
        end else if (rd_addr == AWU_IMSK_ADDR) begin
            rd_val = {30'h0000_0000, st_reg.imsk};
        end else if (rd_addr == AWU_MODE_ADDR) begin
            rd_val = {29'h0000_0000, st_reg.mode};
        end else begin
            rd_ok = 1'b0;
        end
        if (rd_fire) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = rd_val;
            st_next.rresp = rd_ok ? AWU_RESP_OKAY : AWU_RESP_SLVERR;
        end

        // read of control/status clears flag and pending wake request
        if (csr_read) begin
            st_next.csr[AWU_FLAG_BIT] = 1'b0;
            st_next.wake_pend = 1'b0;
        end

        // power mode sequencer
        st_next.resume = 1'b0;
        st_next.imask_en = 1'b0;
        st_next.wdg_rst = 1'b0;
        case (st_reg.mode)
            AWU_RUN: begin
                st_next.main_osc_en = 1'b1;
                st_next.periph_en = 1'b1;
                st_next.fix_cnt = 6'h00; // held at zero while running
                st_next.pre_cnt = st_reg.pr;
                if (halt_exec) begin
                    if (watchdog_enabled && !watchdog_halt_option
                        && !rtc_interrupt_enable) begin
                        st_next.wdg_rst = 1'b1;
                        st_next.mode = AWU_WDG_RESET;
                    end else begin
                        st_next.imask = AWU_IMASK_HALT;
                        st_next.imask_en = 1'b1;
                        st_next.periph_en = 1'b0;
                        if (rtc_interrupt_enable) begin
                            st_next.mode = AWU_ACTIVE_HALT;
                        end else if (st_reg.csr[AWU_EN_BIT]) begin
                            st_next.mode = AWU_WAKE_HALT;
                            st_next.main_osc_en = 1'b0;
                        end else begin
                            st_next.mode = AWU_HALT;
                            st_next.main_osc_en = 1'b0;
                        end
                    end
                end
            end
            AWU_HALT, AWU_ACTIVE_HALT: begin
                // exit on exit-capable interrupt, pending included
                if (halt_exit_irq) begin
                    exit_set = 1'b1;
                    st_next.main_osc_en = 1'b1;
                    st_next.stab_cnt = long_startup_option ?
                        AWU_STAB_LONG_CNT : AWU_STAB_SHORT_CNT;
                    st_next.mode = AWU_STARTUP;
                end
            end
            AWU_WAKE_HALT: begin
                // fixed /64 then prescaler count wake periods
                if (wake_osc_ready && osc_rise) begin
                    st_next.fix_cnt = 6'(st_reg.fix_cnt + 6'h01);
                    if (st_reg.fix_cnt == AWU_FIXED_DIV_LAST) begin
                        st_next.pre_cnt = 8'(st_reg.pre_cnt - 8'h01);
                    end
                end
                if (wake_osc_ready && osc_rise
                    && st_reg.fix_cnt == AWU_FIXED_DIV_LAST
                    && st_reg.pre_cnt <= 8'h01) begin
                    wake_set = 1'b1;
                end
                if (wake_set || halt_exit_irq) begin
                    exit_set = !wake_set && halt_exit_irq;
                    st_next.main_osc_en = 1'b1; // restart at once
                    st_next.stab_cnt = long_startup_option ?
                        AWU_STAB_LONG_CNT : AWU_STAB_SHORT_CNT;
                    st_next.mode = AWU_STARTUP;
                end
            end
            AWU_STARTUP: begin
                // core resumes only after stabilisation
                st_next.stab_cnt = 13'(st_reg.stab_cnt - 13'h0001);
                if (st_reg.stab_cnt <= 13'h0001) begin
                    st_next.resume = 1'b1;
                    st_next.periph_en = 1'b1;
                    st_next.mode = AWU_RUN;
                end
            end
            AWU_WDG_RESET: begin
                st_next.mode = AWU_RUN;
            end
            default: begin
                st_next.mode = AWU_RUN;
            end
        endcase

        // wake flag: hardware set wins over read clear
        if (wake_set) begin
            st_next.csr[AWU_FLAG_BIT] = 1'b1;
            st_next.wake_pend = 1'b1;
            st_next.ist[AWU_IRQ_WAKE] = 1'b1;
        end
        if (exit_set) begin
            st_next.ist[AWU_IRQ_EXIT] = 1'b1;
        end

        // wake oscillator runs in auto wake halt or measurement
        st_next.wake_osc_en = (st_next.mode == AWU_WAKE_HALT)
            || (st_next.mode == AWU_RUN && st_reg.csr[AWU_MEAS_BIT]);
        // wake clock routed to timer capture input two
        st_next.cap2 = st_reg.csr[AWU_MEAS_BIT] && st_reg.mode == AWU_RUN
            && st_reg.osc_q;
        // wake request presented to core once main clock is stable
        st_next.wirq = st_next.wake_pend && st_next.mode == AWU_RUN;
        st_next.irq = |(st_next.ist & st_next.imsk);
    end

    // ******************************************************
    // state register
    // ******************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.csr <= AWU_CSR_RST;
            st_reg.pr <= AWU_PR_RST;
            st_reg.mode <= AWU_RUN; // reset leaves halt
            st_reg.main_osc_en <= 1'b1;
            st_reg.periph_en <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from state flip-flops
    assign s_axi_awready = !st_reg.aw_full;
    assign s_axi_wready = !st_reg.w_full;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign wake_osc_enable = st_reg.wake_osc_en;
    assign main_osc_enable = st_reg.main_osc_en;
    assign periph_clk_enable = st_reg.periph_en;
    assign cpu_resume = st_reg.resume;
    assign interrupt_mask_force = st_reg.imask;
    assign interrupt_mask_force_en = st_reg.imask_en;
    assign watchdog_reset_req = st_reg.wdg_rst;
    assign timer_capture_input_two = st_reg.cap2;
    assign wake_irq = st_reg.wirq;
    assign irq = st_reg.irq;
endmodule

// file: awu_osc_model.sv
// wake rc oscillator model on the far side of the unit
`timescale 1ns/1ns
module awu_osc_model #(
    parameter int START_CYC = 10,
    parameter int HALF_CYC = 2
) (
    input wire logic aclk,
    input wire logic wake_osc_enable,
    output logic wake_osc_clk,
    output logic wake_osc_ready
);
    int cnt = 0;
    initial begin
        wake_osc_clk = 1'b0;
        wake_osc_ready = 1'b0;
    end
    // start-up delay, then free toggling; clock stands low while off
    always @(posedge aclk) begin
        if (wake_osc_enable !== 1'b1) begin
            cnt <= 0;
            wake_osc_ready <= 1'b0;
            wake_osc_clk <= 1'b0;
        end else if (cnt < START_CYC) begin
            cnt <= cnt + 1;
        end else begin
            wake_osc_ready <= 1'b1;
            cnt <= (cnt == START_CYC + HALF_CYC - 1) ? START_CYC : cnt + 1;
            if (cnt == START_CYC) wake_osc_clk <= ~wake_osc_clk;
        end
    end
endmodule

// file: awu_sva.sv
// assertion checker for the auto wake-from-halt unit ports
`timescale 1ns/1ns
module awu_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic halt_exec,
    input wire logic rtc_interrupt_enable,
    input wire logic watchdog_enabled,
    input wire logic watchdog_halt_option,
    input wire logic long_startup_option,
    input wire logic halt_exit_irq,
    input wire logic wake_osc_enable,
    input wire logic main_osc_enable,
    input wire logic periph_clk_enable,
    input wire logic cpu_resume,
    input wire logic [1:0] interrupt_mask_force,
    input wire logic interrupt_mask_force_en,
    input wire logic watchdog_reset_req,
    input wire logic timer_capture_input_two,
    input wire logic wake_irq
);
    import awu_pkg::*;
    localparam int STAB_S = 254;
    localparam int STAB_L = 4094;
    logic [12:0] stab_reg;
    logic [12:0] stab_next;
    // counts cycles with main clock back but peripherals still gated
    always_comb begin
        stab_next = 13'h0;
        if (main_osc_enable && !periph_clk_enable) begin
            // saturates so a long active halt cannot wrap the count
            stab_next = (stab_reg == 13'h1fff) ? stab_reg : 13'(stab_reg + 13'h1);
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stab_reg <= 13'h0;
        end else begin
            stab_reg <= stab_next;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_halt_go;
        periph_clk_enable && halt_exec && (watchdog_halt_option || !watchdog_enabled);
    endsequence
    sequence s_mask_forced;
        interrupt_mask_force_en && (interrupt_mask_force == AWU_IMASK_HALT);
    endsequence
    a_mask_force: assert property (s_halt_go ##0 !rtc_interrupt_enable |=> s_mask_forced)
        else $error("mask not forced on halt entry");
    a_main_stop: assert property (
        s_halt_go ##0 (!rtc_interrupt_enable && !halt_exit_irq)
        |=> !main_osc_enable && !periph_clk_enable)
        else $error("main clock still on in halt");
    a_pend_wake: assert property (
        !main_osc_enable && halt_exit_irq |-> ##[1:3] main_osc_enable)
        else $error("exit interrupt did not restart main clock");
    a_stab_wait: assert property (
        cpu_resume |-> (long_startup_option ? stab_reg >= STAB_L : stab_reg >= STAB_S))
        else $error("resume before start-up wait");
    a_wake_run: assert property (wake_irq |-> periph_clk_enable && main_osc_enable)
        else $error("wake interrupt before stabilisation");
    a_meas_osc: assert property (timer_capture_input_two |-> wake_osc_enable)
        else $error("capture input active with oscillator off");
    a_wdg_reset: assert property (
        periph_clk_enable && halt_exec && watchdog_enabled && !watchdog_halt_option
        && !rtc_interrupt_enable |-> ##[1:2] watchdog_reset_req)
        else $error("watchdog reset missing on halt");
    a_wdg_quiet: assert property (
        periph_clk_enable && halt_exec && watchdog_halt_option |=> !watchdog_reset_req [*2])
        else $error("watchdog reset despite halt option");
endmodule
bind awu_top awu_sva u_awu_sva (.*);

// file: testbench.sv
// self-checking testbench for the auto wake-from-halt unit
`timescale 1ns/1ns
module testbench;
    import awu_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, interrupt_mask_force;
    logic [31:0] s_axi_rdata;
    logic halt_exec = 1'b0, rtc_interrupt_enable = 1'b0, watchdog_enabled = 1'b0;
    logic watchdog_halt_option = 1'b1, long_startup_option = 1'b0, halt_exit_irq = 1'b0;
    logic wake_osc_clk, wake_osc_ready, wake_osc_enable, main_osc_enable, periph_clk_enable;
    logic cpu_resume, interrupt_mask_force_en, watchdog_reset_req, timer_capture_input_two;
    logic wake_irq, irq;
    int fail_count = 0;
    int cmp_count = 0;
    awu_top uut (.*);
    awu_osc_model far (.*);
    always #20 aclk = ~aclk;
    // ****************************************
    // bus and check helpers
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // waits on the answer for as long as it takes; only the hang guard ends a hang
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk("write resp", {30'h0, AWU_RESP_OKAY}, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // picks the output that a wait follows: 0 main osc, 1 resume, 2 watchdog
    function automatic logic watched(input int sel);
        case (sel)
            0: return main_osc_enable;
            1: return cpu_resume;
            default: return watchdog_reset_req;
        endcase
    endfunction
    task automatic wait_for(input int sel, output int n);
        n = 0;
        while (watched(sel) !== 1'b1 && n < 6000) begin
            @(posedge aclk);
            n++;
        end
    endtask
    task automatic hlt();
        halt_exec <= 1'b1;
        @(posedge aclk);
        halt_exec <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(AWU_CSR_ADDR, d, r);
        chk("csr reset", 32'h0, d);
        axi_rd(AWU_PR_ADDR, d, r);
        chk("prescaler reset", 32'hff, d);
        axi_wr(AWU_CSR_ADDR, 32'hff);
        axi_rd(AWU_CSR_ADDR, d, r);
        chk("csr writable bits", 32'h3, d);
        axi_wr(AWU_PR_ADDR, 32'h0);
        axi_rd(AWU_PR_ADDR, d, r);
        chk("prescaler zero", 32'hff, d);
        axi_rd(12'hffc, d, r);
        chk("unmapped resp", {30'h0, AWU_RESP_SLVERR}, {30'h0, r});
        axi_wr(AWU_CSR_ADDR, 32'h0);
    endtask
    task automatic t_wake(input logic [7:0] p, input logic lng);
        int n;
        int m;
        int stab;
        logic [31:0] d;
        logic [1:0] r;
        stab = lng ? AWU_STAB_LONG : AWU_STAB_SHORT;
        long_startup_option <= lng;
        axi_wr(AWU_PR_ADDR, {24'h0, p});
        axi_wr(AWU_IMSK_ADDR, 32'h1);
        axi_wr(AWU_CSR_ADDR, 32'h1);
        hlt();
        chk("wake osc on", 32'h1, wake_osc_enable);
        chk("main osc off", 32'h0, main_osc_enable);
        axi_rd(AWU_MODE_ADDR, d, r);
        chk("wake halt mode", 32'h3, d);
        wait_for(0, n);
        chk("halt length", 32'h1, n >= 256 * p + 3 && n <= 256 * p + 23);
        wait_for(1, m);
        chk("start-up wait", 32'h1, m >= stab - 4 && m <= stab + 4);
        @(posedge aclk);
        chk("wake irq", 32'h1, wake_irq);
        chk("irq line", 32'h1, irq);
        axi_rd(AWU_CSR_ADDR, d, r);
        chk("flag set", 32'h5, d);
        axi_rd(AWU_CSR_ADDR, d, r);
        chk("flag cleared", 32'h1, d);
        chk("wake irq cleared", 32'h0, wake_irq);
        axi_wr(AWU_IST_ADDR, 32'h1);
        chk("irq cleared", 32'h0, irq);
        axi_wr(AWU_CSR_ADDR, 32'h0);
    endtask
    task automatic t_modes();
        int n;
        logic [31:0] d;
        logic [1:0] r;
        watchdog_enabled <= 1'b1;
        rtc_interrupt_enable <= 1'b1;
        // short start-up wait for the exit timings below
        long_startup_option <= 1'b0;
        hlt();
        axi_rd(AWU_MODE_ADDR, d, r);
        chk("active halt", 32'h2, d);
        chk("rtc clock on", 32'h1, main_osc_enable);
        halt_exit_irq <= 1'b1;
        wait_for(1, n);
        chk("active exit", 32'h1, n < 300);
        halt_exit_irq <= 1'b0;
        rtc_interrupt_enable <= 1'b0;
        hlt();
        axi_rd(AWU_MODE_ADDR, d, r);
        chk("plain halt", 32'h1, d);
        chk("no wake osc", 32'h0, wake_osc_enable);
        repeat (40) @(posedge aclk);
        chk("stays halted", 32'h0, main_osc_enable);
        halt_exit_irq <= 1'b1;
        wait_for(1, n);
        chk("irq exit", 32'h1, n < 264);
        hlt();
        wait_for(1, n);
        chk("pending wake", 32'h1, n < 264);
        halt_exit_irq <= 1'b0;
        axi_wr(AWU_IST_ADDR, 32'h3);
    endtask
    task automatic t_meas();
        int n = 0;
        logic prev;
        axi_wr(AWU_CSR_ADDR, 32'h2);
        prev = timer_capture_input_two;
        repeat (64) begin
            @(posedge aclk);
            if (timer_capture_input_two !== prev) n++;
            prev = timer_capture_input_two;
        end
        chk("meas osc on", 32'h1, wake_osc_enable);
        chk("capture toggles", 32'h1, n >= 20);
        axi_wr(AWU_CSR_ADDR, 32'h0);
    endtask
    task automatic t_wdg();
        int n;
        logic [31:0] d;
        logic [1:0] r;
        watchdog_halt_option <= 1'b0;
        hlt();
        wait_for(2, n);
        chk("watchdog reset", 32'h1, n < 3);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(AWU_PR_ADDR, d, r);
        chk("prescaler rereset", 32'hff, d);
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_wake(8'h01, 1'b0);
        t_wake(8'h03, 1'b1);
        t_modes();
        t_meas();
        t_wdg();
        give_verdict();
    end
    // hang guard well beyond the expected run length
    initial begin
        repeat (40000) @(posedge aclk);
        fail_count++;
        give_verdict();
    end
endmodule
